// >>> hw/lise_pkg.sv
// Purpose: constants for the per-link interrupt status and enable block
// Assumes: 16-bit host register port, direct addressing
// Notes: all sizes fixed at the device values
package lise_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_LINKS = 16;
  localparam int NUM_GROUPS = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 11;
  localparam int STAT_W = 12;
  localparam int IDX_W = 4;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] STATUS_BASE = 11'h435;
  localparam logic [ADDR_W-1:0] ENABLE_BASE = 11'h445;
  localparam logic [ADDR_W-1:0] MASTER_STATUS_ADDR = 11'h455;
  localparam logic [ADDR_W-1:0] BANK_SIZE = 11'h010;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RESET = 12'h000;
  localparam logic [DATA_W-STAT_W-1:0] UNUSED_HI = 4'h0;

  // ****************************************************************
  // status bit positions
  // ****************************************************************
  localparam int BIT_DSYNC_END = 11;
  localparam int BIT_FRAME_END = 10;
  localparam int BIT_CDEL_END = 9;
  localparam int BIT_GRP_OVF = 8;
  localparam int BIT_GRP_EVT = 7;
  localparam int BIT_PRE_OVF = 6;
  localparam int BIT_CELL_CHG = 5;
  localparam int BIT_VIOL = 4;
  localparam int BIT_DSYNC = 3;
  localparam int BIT_FRAME = 2;
  localparam int BIT_CDEL = 1;
  localparam int BIT_CNT_OVF = 0;
  localparam int LINK_ZERO = 0;

  // bits that a written zero clears; 8 and 0 follow their sources
  localparam logic [STAT_W-1:0] CLEARABLE_MASK = 12'hEFE;
  // bits present only in the link 0 register
  localparam logic [STAT_W-1:0] LINK0_ONLY_MASK = 12'h180;

endpackage

// >>> hw/lise_edge.sv
// Purpose: rise and fall pulse detector for a vector of levels
// Assumes: inputs synchronous to sys_clk
// Notes: pulses are combinational from the held previous level
`timescale 1ns/100ps
module lise_edge #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // levels in
  input wire logic [W-1:0] level,
  // edge pulses out
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import lise_pkg::*;

  typedef struct packed {
    logic [W-1:0] prev;
  } lise_edge_st_t;

  lise_edge_st_t state;
  lise_edge_st_t next_state;

  always_comb begin
    next_state = state;
    next_state.prev = level;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // a level already high at reset release reads as a rise
  assign rise = level & ~state.prev;
  assign fall = ~level & state.prev;

endmodule

// >>> hw/lise_req_gen.sv
// Purpose: per-link request = OR of enabled status bits
// Assumes: status and enable held in the caller
// Notes: purely combinational, evaluated every cycle
`timescale 1ns/100ps
module lise_req_gen (
  // status and enables, one 12-bit slice per link
  input wire logic [lise_pkg::NUM_LINKS-1:0][lise_pkg::STAT_W-1:0] status,
  input wire logic [lise_pkg::NUM_LINKS-1:0][lise_pkg::STAT_W-1:0] enable,
  // one request per link
  output logic [lise_pkg::NUM_LINKS-1:0] req
);
  import lise_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : gLink
      assign req[g] = |(status[g] & enable[g]);
    end
  endgenerate

endmodule

// >>> hw/lise_top.sv
// Purpose: per-link interrupt status and enable registers, link
//   requests, master status view and the active-low interrupt pin
// Assumes: host port strobes are single-cycle and synchronous;
//   condition and event inputs are synchronous to sys_clk
// Notes: reads return data one cycle after the strobe
`timescale 1ns/100ps
module lise_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,

  // host register port
  input wire logic [lise_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lise_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [lise_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,

  // per-link alarm conditions, levels
  input wire logic [lise_pkg::NUM_LINKS-1:0] delaySyncLoss,
  input wire logic [lise_pkg::NUM_LINKS-1:0] frameLoss,
  input wire logic [lise_pkg::NUM_LINKS-1:0] cellDelineationLoss,

  // per-link control cell events, one-cycle pulses
  input wire logic [lise_pkg::NUM_LINKS-1:0] controlCellViolation,
  input wire logic [lise_pkg::NUM_LINKS-1:0] controlProtocolCellChanged,
  input wire logic [lise_pkg::NUM_LINKS-1:0] preprocOverflow,

  // per-link counter overflow summary, level
  input wire logic [lise_pkg::NUM_LINKS-1:0] linkCounterOverflow,

  // group sources, reported in link 0 only
  input wire logic [lise_pkg::NUM_GROUPS-1:0] txCellReady,
  input wire logic [lise_pkg::NUM_GROUPS-1:0] groupFramePulse,
  input wire logic groupOverflowPending,

  // master enable, one bit per link
  input wire logic [lise_pkg::NUM_LINKS-1:0] masterEnable,

  // requests and pin
  output logic [lise_pkg::NUM_LINKS-1:0] linkIrqReq,
  output logic irqPin_b
);
  import lise_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NUM_LINKS-1:0][STAT_W-1:0] status;
    logic [NUM_LINKS-1:0][STAT_W-1:0] enable;
    logic [NUM_LINKS-1:0] linkReq;
    logic irqPinB;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
  } lise_top_st_t;

  lise_top_st_t state;
  lise_top_st_t next_state;

  // ****************************************************************
  // edge detection on alarm levels and transfer-ready bits
  // ****************************************************************
  logic [NUM_LINKS-1:0] dsyncEnd;
  logic [NUM_LINKS-1:0] frameEnd;
  logic [NUM_LINKS-1:0] cdelEnd;
  logic [NUM_GROUPS-1:0] readyRise;

  lise_edge #(.W(NUM_LINKS)) uDsyncEdge (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .level (delaySyncLoss),
    .rise (),
    .fall (dsyncEnd)
  );

  lise_edge #(.W(NUM_LINKS)) uFrameEdge (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .level (frameLoss),
    .rise (),
    .fall (frameEnd)
  );

  lise_edge #(.W(NUM_LINKS)) uCdelEdge (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .level (cellDelineationLoss),
    .rise (),
    .fall (cdelEnd)
  );

  // transfer complete is the ready bit returning to one
  lise_edge #(.W(NUM_GROUPS)) uReadyEdge (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .level (txCellReady),
    .rise (readyRise),
    .fall ()
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic statusHit;
  logic enableHit;
  logic masterHit;
  logic [ADDR_W-1:0] statusOff;
  logic [ADDR_W-1:0] enableOff;
  logic [IDX_W-1:0] statusIdx;
  logic [IDX_W-1:0] enableIdx;

  assign statusOff = regAddr - STATUS_BASE;
  assign enableOff = regAddr - ENABLE_BASE;
  // unsigned wrap makes addresses below the base miss as well
  assign statusHit = statusOff < BANK_SIZE;
  assign enableHit = enableOff < BANK_SIZE;
  assign masterHit = regAddr == MASTER_STATUS_ADDR;
  assign statusIdx = statusOff[IDX_W-1:0];
  assign enableIdx = enableOff[IDX_W-1:0];

  // ****************************************************************
  // request generation from the next status and enables
  // ****************************************************************
  logic [NUM_LINKS-1:0] nextReq;

  lise_req_gen uReqGen (
    .status (next_state.status),
    .enable (next_state.enable),
    .req (nextReq)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [STAT_W-1:0] setBits;
  logic [STAT_W-1:0] clrBits;
  logic [STAT_W-1:0] newStat;
  logic grpEvent;

  always_comb begin
    next_state = state;
    setBits = STAT_RESET;
    clrBits = STAT_RESET;
    newStat = STAT_RESET;
    grpEvent = (|readyRise) | (|groupFramePulse);

    for (int i = 0; i < NUM_LINKS; i++) begin
      setBits = STAT_RESET;
      setBits[BIT_DSYNC_END] = dsyncEnd[i];
      setBits[BIT_FRAME_END] = frameEnd[i];
      setBits[BIT_CDEL_END] = cdelEnd[i];
      setBits[BIT_GRP_EVT] = grpEvent;
      setBits[BIT_PRE_OVF] = preprocOverflow[i];
      setBits[BIT_CELL_CHG] = controlProtocolCellChanged[i];
      setBits[BIT_VIOL] = controlCellViolation[i];
      setBits[BIT_DSYNC] = delaySyncLoss[i];
      setBits[BIT_FRAME] = frameLoss[i];
      setBits[BIT_CDEL] = cellDelineationLoss[i];

      // a written zero clears; ones leave the bit alone
      clrBits = STAT_RESET;
      if (regWr && statusHit && statusIdx == IDX_W'(i)) begin
        clrBits = ~regWrData[STAT_W-1:0] & CLEARABLE_MASK;
      end

      // set wins over a clear in the same cycle
      newStat = (state.status[i] & ~clrBits) | setBits;

      // these two only ever mirror their sources
      newStat[BIT_GRP_OVF] = groupOverflowPending;
      newStat[BIT_CNT_OVF] = linkCounterOverflow[i];

      // group bits live in link 0 only
      if (i != LINK_ZERO) begin
        newStat = newStat & ~LINK0_ONLY_MASK;
      end
      next_state.status[i] = newStat;

      if (regWr && enableHit && enableIdx == IDX_W'(i)) begin
        next_state.enable[i] = regWrData[STAT_W-1:0];
      end
    end

    // master status is the unlatched request view
    next_state.linkReq = nextReq;
    next_state.irqPinB = ~|(nextReq & masterEnable);

    // reads have no side effects; writes to master status are dropped
    next_state.rdValid = regRd;
    next_state.rdData = REG_RESET;
    if (regRd) begin
      if (statusHit) begin
        next_state.rdData = {UNUSED_HI, state.status[statusIdx]};
      end else if (enableHit) begin
        next_state.rdData = {UNUSED_HI, state.enable[enableIdx]};
      end else if (masterHit) begin
        next_state.rdData = state.linkReq;
      end else begin
        next_state.rdData = REG_RESET;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
      // pin is idle high out of reset
      state.irqPinB <= 1'h1;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign regRdData = state.rdData;
  assign regRdValid = state.rdValid;
  assign linkIrqReq = state.linkReq;
  assign irqPin_b = state.irqPinB;

endmodule

// >>> bench/lise_top_assertions.sv
// Purpose: port checks for the link interrupt block
// Assumes: one clock domain, reset active low
// Notes: bound to lise_top after the module
`timescale 1ns/100ps
module lise_top_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // host port
  input wire logic [lise_pkg::ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic [lise_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid,
  // sources and requests
  input wire logic [lise_pkg::NUM_LINKS-1:0] linkCounterOverflow,
  input wire logic groupOverflowPending,
  input wire logic [lise_pkg::NUM_LINKS-1:0] masterEnable,
  input wire logic [lise_pkg::NUM_LINKS-1:0] linkIrqReq,
  input wire logic irqPin_b
);
  import lise_pkg::*;
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  rd_answer_a: assert property (regRd |=> regRdValid)
    else $error("read strobe without answer");
  answer_cause_a: assert property (regRdValid |-> $past(regRd))
    else $error("answer without strobe");
  idle_zero_a: assert property (
    !regRdValid |-> regRdData == '0)
    else $error("read data not zero outside answer");
  high_zero_a: assert property (
    regRdValid |-> regRdData[15:12] == 4'h0)
    else $error("upper bits not zero");
  only_link0_a: assert property (
    regRd && regAddr > STATUS_BASE && regAddr < ENABLE_BASE
    |=> regRdData[8:7] == 2'h0)
    else $error("group bits seen outside link 0");
  master_view_a: assert property (
    regRd && regAddr == MASTER_STATUS_ADDR
    |=> regRdData == $past(linkIrqReq))
    else $error("master status differs from requests");
  // two-cycle lag: source sampled, then status, then read data
  mirror_bits_a: assert property (
    regRd && regAddr == STATUS_BASE && $past(rst_b)
    |=> regRdData[0] == $past(linkCounterOverflow[0], 2) &&
    regRdData[8] == $past(groupOverflowPending, 2))
    else $error("mirror bit wrong");
  pin_level_a: assert property (
    irqPin_b == !(|(linkIrqReq & $past(masterEnable))))
    else $error("pin level wrong");
  unmapped_a: assert property (
    regRd && (regAddr < STATUS_BASE || regAddr > MASTER_STATUS_ADDR)
    |=> regRdData == '0)
    else $error("unmapped read not zero");
endmodule
bind lise_top lise_top_assertions chk_u (.sys_clk, .rst_b, .regAddr,
  .regRd, .regRdData, .regRdValid, .linkCounterOverflow,
  .groupOverflowPending, .masterEnable, .linkIrqReq, .irqPin_b);

// >>> bench/tb.sv
// Purpose: self-checking bench for lise_top
// Assumes: inputs driven on the falling edge
// Notes: events are spread over links 0, 3, 6, 9, 12 and 15
`timescale 1ns/100ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errCount++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import lise_pkg::*;
  logic sys_clk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0;
  logic regRdValid, irqPin_b, groupOverflowPending = 1'h0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData;
  logic [NUM_LINKS-1:0] delaySyncLoss = '0, frameLoss = '0,
    cellDelineationLoss = '0, controlCellViolation = '0,
    controlProtocolCellChanged = '0, preprocOverflow = '0,
    linkCounterOverflow = '0, masterEnable = '0, linkIrqReq, ev;
  logic [NUM_GROUPS-1:0] txCellReady = '0, groupFramePulse = '0;
  int errCount = 0, nTests = 0, cyc = 0, lk;
  localparam logic [ADDR_W-1:0] RW_ADDR [5] = '{ENABLE_BASE, 11'h454,
    11'h436, MASTER_STATUS_ADDR, 11'h7FF};
  localparam logic [DATA_W-1:0] RW_DATA [5] = '{16'hFFFF, 16'hA5A5,
    16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic [DATA_W-1:0] RW_EXP [5] = '{16'h0FFF, 16'h05A5,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [DATA_W-1:0] EV_EXP [8] = '{16'h0010, 16'h0020,
    16'h0040, 16'h0808, 16'h0404, 16'h0202, 16'h0080, 16'h0080};

  lise_top dut_u (.sys_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .regRdValid, .delaySyncLoss, .frameLoss,
    .cellDelineationLoss, .controlCellViolation, .controlProtocolCellChanged,
    .preprocOverflow, .linkCounterOverflow, .txCellReady, .groupFramePulse,
    .groupOverflowPending, .masterEnable, .linkIrqReq, .irqPin_b);

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // a hang is cut short well past the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      errCount++;
      completeRun();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic completeRun();
    if (errCount == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input int a, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    regAddr = ADDR_W'(a);
    regWrData = d;
    regWr = 1'h1;
    @(negedge sys_clk);
    regWr = 1'h0;
  endtask
  task automatic rd(input int a, input logic [DATA_W-1:0] e);
    @(negedge sys_clk);
    regAddr = ADDR_W'(a);
    regRd = 1'h1;
    @(negedge sys_clk);
    regRd = 1'h0;
    `CHK(regRdValid, 1'h1)
    `CHK(regRdData, e)
  endtask
  task automatic irq(input logic [NUM_LINKS-1:0] r);
    `CHK(linkIrqReq, r)
    `CHK(irqPin_b, ~|(r & masterEnable))
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_b = 1'h1;
    for (int i = 0; i < 32; i++) rd(STATUS_BASE + i, REG_RESET);
    for (int i = 0; i < 5; i++) begin
      wr(RW_ADDR[i], RW_DATA[i]);
      rd(RW_ADDR[i], RW_EXP[i]);
    end
    masterEnable = '1;
    for (int i = 0; i < 16; i++) wr(ENABLE_BASE + i, 16'h0FFF);
    for (int k = 0; k < 8; k++) begin
      lk = (k > 5) ? 0 : 3 * k;
      ev = 16'h0001 << lk;
      @(negedge sys_clk);
      case (k)
        0: controlCellViolation = ev;
        1: controlProtocolCellChanged = ev;
        2: preprocOverflow = ev;
        3: delaySyncLoss = ev;
        4: frameLoss = ev;
        5: cellDelineationLoss = ev;
        6: txCellReady = 8'h08;
        default: groupFramePulse = 8'h20;
      endcase
      @(negedge sys_clk);
      {controlCellViolation, controlProtocolCellChanged, preprocOverflow,
        delaySyncLoss, frameLoss, cellDelineationLoss} = '0;
      {txCellReady, groupFramePulse} = '0;
      irq(ev);
      rd(STATUS_BASE + lk,
        EV_EXP[k]);
      // group event bit must stay out of the other links
      if (k > 5) rd(STATUS_BASE + 1, REG_RESET);
      wr(STATUS_BASE + lk, ~EV_EXP[k]);
      rd(STATUS_BASE + lk, REG_RESET);
      irq('0);
    end
    linkCounterOverflow = 16'h0010;
    groupOverflowPending = 1'h1;
    wr(STATUS_BASE, REG_RESET);
    wr(STATUS_BASE + 4, REG_RESET);
    rd(STATUS_BASE, 16'h0100);
    rd(STATUS_BASE + 4, 16'h0001);
    rd(MASTER_STATUS_ADDR, 16'h0011);
    masterEnable = 16'hFFEE;
    @(negedge sys_clk);
    irq(16'h0011);
    {linkCounterOverflow, groupOverflowPending} = '0;
    masterEnable = '1;
    rd(STATUS_BASE, REG_RESET);
    irq('0);
    wr(ENABLE_BASE + 2, 16'h0FEF);
    @(negedge sys_clk);
    controlCellViolation = 16'h0004;
    @(negedge sys_clk);
    controlCellViolation = '0;
    irq('0);
    wr(ENABLE_BASE + 2, 16'h0FFF);
    @(negedge sys_clk);
    irq(16'h0004);
    // a held level must win over the clearing write
    delaySyncLoss = 16'h0040;
    wr(STATUS_BASE + 6, REG_RESET);
    rd(STATUS_BASE + 6, 16'h0008);
    delaySyncLoss = '0;
    rd(STATUS_BASE + 6, 16'h0808);
    @(negedge sys_clk);
    rst_b = 1'h0;
    @(negedge sys_clk);
    irq('0);
    rst_b = 1'h1;
    rd(STATUS_BASE + 2, REG_RESET);
    rd(ENABLE_BASE + 2, REG_RESET);
    completeRun();
  end
endmodule
